// ### core/qpfet_core_timing.sv
// Core timing: phases, two-stage fetch/execute pipeline and quarter-rate clock
`timescale 1ns/1ps
module qpfet_core_timing
   import qpfet_pkg::*;
#(
   // Program counter width sets the reach of program space
   parameter int PC_WIDTH   = 11,
   // Instruction word width, as stored in program memory
   parameter int WORD_WIDTH = 12
)(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  master_reset_n,
   input  wire logic                  rc_mode,
   input  wire logic [WORD_WIDTH-1:0] program_word,
   input  wire logic                  pc_load,
   input  wire logic [PC_WIDTH-1:0]   pc_target,
   output logic      [PC_WIDTH-1:0]   program_address,
   output logic      [WORD_WIDTH-1:0] instruction,
   output logic                       instruction_valid,
   output logic                       phase_one,
   output logic                       phase_two,
   output logic                       phase_three,
   output logic                       phase_four,
   output logic                       operand_read,
   output logic                       destination_write,
   output logic                       oscillator_secondary_pin,
   output logic                       oscillator_secondary_oe
);
   import qpfet_pkg::*;

   // Master reset and mode pins are asynchronous to the core clock, so each
   // passes two flip-flops; the first stage only feeds the second. The price
   // is two cycles of latency on entry to and exit from pin reset.
   logic [SYNC_STAGES-1:0] resetSync;
   logic [SYNC_STAGES-1:0] next_resetSync;
   logic                   coreReset;
   logic                   rcSync1;
   logic                   rcSync2;
   logic                   next_rcSync1;
   logic                   next_rcSync2;

   // Shift the pin levels one stage per clock
   always_comb
   begin
      next_resetSync = {resetSync[SYNC_STAGES-2:0], master_reset_n};
      next_rcSync1   = rc_mode;
      next_rcSync2   = rcSync1;
   end

   // Synchroniser flops clear only on the system reset, not on the pin reset they make
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         resetSync <= '0;
         rcSync1   <= 1'b0;
         rcSync2   <= 1'b0;
      end
      else
      begin
         resetSync <= next_resetSync;
         rcSync1   <= next_rcSync1;
         rcSync2   <= next_rcSync2;
      end
   end

   // Low on the pin holds the phase ring, pipeline and outputs in reset; the synchronisers keep running
   assign coreReset = reset | ~resetSync[SYNC_STAGES-1];

   // Divide-by-four ring, parked in phase four while any reset is held
   qpfet_phase_e phase;

   qpfet_phase_gen qpfet_phase_gen_inst
   (
      .clock (clock),
      .reset (coreReset),
      .phase (phase)
   );

   // Pipeline state
   logic [PC_WIDTH-1:0]   pc;
   logic [PC_WIDTH-1:0]   next_pc;
   logic [WORD_WIDTH-1:0] fetchLatch;
   logic [WORD_WIDTH-1:0] next_fetchLatch;
   logic                  fetchValid;
   logic                  next_fetchValid;
   logic                  instructionValid;
   logic                  jumpTaken;
   logic [WORD_WIDTH-1:0] next_instruction;
   logic                  next_instructionValid;
   logic [PC_WIDTH-1:0]   next_programAddress;
   logic                  next_phaseOne;
   logic                  next_phaseTwo;
   logic                  next_phaseThree;
   logic                  next_phaseFour;
   logic                  next_operandRead;
   logic                  next_destinationWrite;
   logic                  next_quarter_rate_clock_output;
   logic                  next_clkOutOe;

   // A jump is honoured only from a live instruction at the close of phase four;
   // a no-operation slot ignores the request, so one flush cannot chain another
   assign jumpTaken = (phase == PH_FOUR) && pc_load && instructionValid;

   // Fetch and execute overlap: while the register executes, the latch fills.
   // A jump target is taken in phase four, so the word fetched that cycle is
   // stale and is executed as a no-operation, costing one extra cycle.
   always_comb
   begin
      next_pc               = pc;
      next_fetchLatch       = fetchLatch;
      next_fetchValid       = fetchValid;
      next_instruction      = instruction;
      next_instructionValid = instructionValid;
      unique case (phase)
         PH_FOUR:
         begin
            // Next cycle is phase one: advance address and move word to execute
            // Address wraps from the top of program space back to zero
            next_pc               = pc + PC_WIDTH'(1);
            next_instruction      = fetchValid ? fetchLatch : NOP_WORD;
            next_instructionValid = fetchValid;
         end
         PH_THREE:
         begin
            // Word latched as phase four begins
            next_fetchLatch = program_word;
            next_fetchValid = 1'b1;
         end
         PH_ONE:
         begin
            // Latch counts as empty until the next fill, so a word from before
            // a reset can never reach the instruction register
            next_fetchValid = 1'b0;
         end
         PH_TWO:
         begin
            // Operand read and execution belong to the datapath; nothing to step
         end
         default:
         begin
         end
      endcase
      // Executing jump redirects the fetch address and voids the prefetch;
      // the word already in the latch is the sequential one and is dropped
      if (jumpTaken)
      begin
         next_pc               = pc_target;
         next_instruction      = NOP_WORD;
         next_instructionValid = 1'b0;
      end
   end

   // Valid flag leaves the block straight from its flop
   assign instruction_valid = instructionValid;

   // Phase strobes are registered one cycle early so they align with phase;
   // decoding from the ring state one phase ahead keeps the outputs glitch free
   // and costs no extra cycle of latency
   always_comb
   begin
      next_programAddress   = next_pc;
      next_phaseOne         = (phase == PH_FOUR);
      next_phaseTwo         = (phase == PH_ONE);
      next_phaseThree       = (phase == PH_TWO);
      next_phaseFour        = (phase == PH_THREE);
      next_operandRead      = (phase == PH_ONE) && instructionValid;
      next_destinationWrite = (phase == PH_THREE) && instructionValid;
      // High in phases one and two, low in three and four: quarter rate
      next_quarter_rate_clock_output           = (phase == PH_FOUR) || (phase == PH_ONE);
      // Mode pin only steers the pin driver; the divider itself never stops
      next_clkOutOe         = rcSync2;
   end

   // Pipeline and output registers; every top-level output leaves from a flop.
   // Strobes idle low in reset so no phase is ever seen while held.
   always_ff @(posedge clock)
   begin
      if (coreReset)
      begin
         pc                       <= PC_RESET;
         fetchLatch               <= NOP_WORD;
         fetchValid               <= 1'b0;
         instruction              <= NOP_WORD;
         instructionValid         <= 1'b0;
         program_address          <= PC_RESET;
         phase_one                <= 1'b0;
         phase_two                <= 1'b0;
         phase_three              <= 1'b0;
         phase_four               <= 1'b0;
         operand_read             <= 1'b0;
         destination_write        <= 1'b0;
         oscillator_secondary_pin <= 1'b0;
         oscillator_secondary_oe  <= 1'b0;
      end
      else
      begin
         pc                       <= next_pc;
         fetchLatch               <= next_fetchLatch;
         fetchValid               <= next_fetchValid;
         instruction              <= next_instruction;
         instructionValid         <= next_instructionValid;
         program_address          <= next_programAddress;
         phase_one                <= next_phaseOne;
         phase_two                <= next_phaseTwo;
         phase_three              <= next_phaseThree;
         phase_four               <= next_phaseFour;
         operand_read             <= next_operandRead;
         destination_write        <= next_destinationWrite;
         oscillator_secondary_pin <= next_quarter_rate_clock_output & next_clkOutOe;
         oscillator_secondary_oe  <= next_clkOutOe;
      end
   end
endmodule : qpfet_core_timing

// ### core/qpfet_phase_gen.sv
// Divide-by-four phase generator producing one-hot non-overlapping phases
`timescale 1ns/1ps
module qpfet_phase_gen
   import qpfet_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                reset,
   output qpfet_pkg::qpfet_phase_e  phase
);
   import qpfet_pkg::*;

   qpfet_phase_e next_phase;

   // Ring advance; reset parks in phase four so the first cycle starts in phase one
   always_comb
   begin
      unique case (phase)
         PH_ONE:   next_phase = PH_TWO;
         PH_TWO:   next_phase = PH_THREE;
         PH_THREE: next_phase = PH_FOUR;
         PH_FOUR:  next_phase = PH_ONE;
         default:  next_phase = PH_ONE;
      endcase
   end

   // Phase register
   always_ff @(posedge clock)
   begin
      if (reset)
         phase <= PH_FOUR;
      else
         phase <= next_phase;
   end
endmodule : qpfet_phase_gen

// ### shared/qpfet_pkg.sv
// Shared constants for the quad-phase fetch/execute timing block
package qpfet_pkg;
   // Phase counter encoding: one instruction cycle is four oscillator periods
   localparam int               PHASE_COUNT   = 4;
   localparam logic [1:0]       PHASE_ONE_IDX = 2'h0;
   localparam logic [1:0]       PHASE_TWO_IDX = 2'h1;
   localparam logic [1:0]       PHASE_THR_IDX = 2'h2;
   localparam logic [1:0]       PHASE_FOU_IDX = 2'h3;
   // Reset values
   localparam logic [1:0]       PHASE_RESET   = 2'h3;
   localparam logic [10:0]      PC_RESET      = 11'h000;
   localparam logic [11:0]      NOP_WORD      = 12'h000;
   // Synchroniser depth for pin inputs
   localparam int               SYNC_STAGES   = 2;
   // Phase one-hot codes
   typedef enum logic [3:0] {
      PH_ONE   = 4'h1,
      PH_TWO   = 4'h2,
      PH_THREE = 4'h4,
      PH_FOUR  = 4'h8
   } qpfet_phase_e;
endpackage : qpfet_pkg

// ### test/qpfet_core_timing_chk.sv
// Concurrent checks on the core timing ports
`timescale 1ns/1ps
module qpfet_core_timing_chk #(
   parameter int PC_WIDTH   = 11,
   parameter int WORD_WIDTH = 12
)(
   input wire logic                  clock,
   input wire logic                  reset,
   input wire logic                  master_reset_n,
   input wire logic                  pc_load,
   input wire logic [PC_WIDTH-1:0]   pc_target,
   input wire logic [WORD_WIDTH-1:0] program_word,
   input wire logic [PC_WIDTH-1:0]   program_address,
   input wire logic [WORD_WIDTH-1:0] instruction,
   input wire logic                  instruction_valid,
   input wire logic                  phase_one,
   input wire logic                  phase_two,
   input wire logic                  phase_three,
   input wire logic                  phase_four,
   input wire logic                  operand_read,
   input wire logic                  destination_write,
   input wire logic                  oscillator_secondary_pin,
   input wire logic                  oscillator_secondary_oe
);
   // Pin reset aborts attempts at once, before its synchroniser lands
   default clocking @(posedge clock); endclocking
   default disable iff (reset || !master_reset_n);
   logic late;
   logic jmp;
   // Late phases, and a jump accepted at the end of phase four
   assign late = phase_two || phase_three || phase_four;
   assign jmp = phase_four && instruction_valid && pc_load;
   chk_phase_onehot: assert property (
      $onehot0({phase_one, phase_two, phase_three, phase_four}))
      else $error("phases overlap");
   chk_phase_period: assert property (
      phase_one |-> ##4 phase_one)
      else $error("instruction cycle not four clocks");
   chk_phase_shift: assert property (
      late |-> {phase_two, phase_three, phase_four}
               == $past({phase_one, phase_two, phase_three}))
      else $error("phase out of order");
   chk_pc_steady: assert property (
      late |-> $stable(program_address))
      else $error("address moved outside phase one");
   chk_pc_increment: assert property (
      phase_four && !jmp |=> program_address == $past(program_address) + 1'b1)
      else $error("address did not step");
   chk_instr_hold: assert property (
      late |-> $stable(instruction) && $stable(instruction_valid))
      else $error("instruction changed mid cycle");
   chk_fetch_latch: assert property (
      phase_three ##1 (phase_four && !jmp)
      |=> instruction_valid && instruction == $past(program_word, 2))
      else $error("fetched word not latched");
   chk_jump_flush: assert property (
      jmp |=> (!instruction_valid && program_address == $past(pc_target))
              ##4 instruction_valid)
      else $error("jump not flushed");
   chk_operand_read: assert property (
      operand_read == (phase_two && instruction_valid))
      else $error("operand read misplaced");
   chk_dest_write: assert property (
      destination_write == (phase_four && instruction_valid))
      else $error("destination write misplaced");
   chk_quarter_clock: assert property (
      oscillator_secondary_pin == (oscillator_secondary_oe && (phase_one || phase_two)))
      else $error("quarter clock wrong");
endmodule : qpfet_core_timing_chk

// ### test/qpfet_core_timing_tb.sv
// Self-checking bench for the quad-phase core timing block
`timescale 1ns/1ps
module qpfet_core_timing_tb;
   import qpfet_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        master_reset_n = 1'b1;
   logic        rc_mode = 1'b0;
   logic        pc_load = 1'b0;
   logic [10:0] pc_target = 11'h000;
   logic [11:0] program_word, instruction, expInstr;
   logic [10:0] program_address, expPc;
   logic        instruction_valid, phase_one, phase_two, phase_three, phase_four, expValid;
   logic        operand_read, destination_write, oscillator_secondary_pin, oscillator_secondary_oe;
   int          n_fail = 0;
   int          total_checks = 0;
   logic [11:0] snap;
   qpfet_core_timing qpfet_core_timing_inst
   (
      .clock                    (clock),
      .reset                    (reset),
      .master_reset_n           (master_reset_n),
      .rc_mode                  (rc_mode),
      .program_word             (program_word),
      .pc_load                  (pc_load),
      .pc_target                (pc_target),
      .program_address          (program_address),
      .instruction              (instruction),
      .instruction_valid        (instruction_valid),
      .phase_one                (phase_one),
      .phase_two                (phase_two),
      .phase_three              (phase_three),
      .phase_four               (phase_four),
      .operand_read             (operand_read),
      .destination_write        (destination_write),
      .oscillator_secondary_pin (oscillator_secondary_pin),
      .oscillator_secondary_oe  (oscillator_secondary_oe)
   );
   qpfet_prog_mem qpfet_prog_mem_inst (.address(program_address), .word(program_word));
   // Oscillator, 4 ns period
   initial forever #2 clock = ~clock;
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Bounded wait, sampled at the falling edge where outputs are settled
   task automatic waitPhase(input logic [3:0] m);
      for (int n = 0; n < 8; n++)
      begin
         @(negedge clock);
         if ({phase_four, phase_three, phase_two, phase_one} === m)
            return;
      end
      check("phase wait", 12'h000, 12'h001);
   endtask : waitPhase
   // Program memory contents as the partner model holds them
   function automatic logic [11:0] expWord(input logic [10:0] a);
      return {1'b0, a} ^ 12'h5a3;
   endfunction : expWord
   // After any reset the first cycle shows the stepped address and no instruction
   task automatic expAfterReset();
      expPc = PC_RESET + 11'h001;
      expInstr = NOP_WORD;
      expValid = 1'b0;
   endtask : expAfterReset
   // Random jumps, refused ones in flush cycles, and a jump to the top address
   task automatic runSeg(input logic rc, input int cycles);
      logic        jump;
      logic [10:0] t;
      rc_mode <= rc;
      for (int k = 0; k < cycles; k++)
      begin
         waitPhase(4'h1);
         check("address", {1'b0, program_address}, {1'b0, expPc});
         check("instruction", instruction, expInstr);
         check("valid", {11'h000, instruction_valid}, {11'h000, expValid});
         // A mode change needs three edges to reach the pin driver
         if (k > 0)
         begin
            snap = {10'h000, oscillator_secondary_pin, oscillator_secondary_oe};
            check("clock out", snap, {10'h000, rc, rc});
         end
         waitPhase(4'h4);
         // Slot two never jumps, so the top-address jump in slot three always lands
         jump = (k == 3) || (k > 0 && k != 2 && $urandom_range(2) == 0);
         t = (k == 3) ? 11'h7ff : 11'($urandom);
         @(posedge clock);
         pc_load <= jump;
         pc_target <= t;
         @(posedge clock);
         pc_load <= 1'b0;
         if (jump && expValid)
         begin
            expPc = t;
            expInstr = NOP_WORD;
            expValid = 1'b0;
         end
         else
         begin
            expInstr = expWord(expPc);
            expPc = expPc + 11'h001;
            expValid = 1'b1;
         end
      end
      $display("test segment rc %0d done", rc);
   endtask : runSeg
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // Main sequence: two oscillator modes, then a pin reset mid-run
   initial
   begin
      void'($urandom(65148));
      expAfterReset();
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      runSeg(1'b0, 40);
      runSeg(1'b1, 40);
      @(posedge clock);
      master_reset_n <= 1'b0;
      repeat (6) @(negedge clock);
      snap = {5'h00, phase_one, phase_two, phase_three, phase_four, instruction_valid,
              oscillator_secondary_pin, oscillator_secondary_oe};
      check("pin reset", snap, 12'h000);
      check("reset address", {1'b0, program_address}, {1'b0, PC_RESET});
      $display("test pin reset done");
      @(posedge clock);
      master_reset_n <= 1'b1;
      expAfterReset();
      runSeg(1'b1, 20);
      conclude();
   end
   // Watchdog, far beyond the expected run length
   initial
   begin
      repeat (5000) @(posedge clock);
      n_fail++;
      conclude();
   end
endmodule : qpfet_core_timing_tb
bind qpfet_core_timing qpfet_core_timing_chk #(.PC_WIDTH(PC_WIDTH), .WORD_WIDTH(WORD_WIDTH))
   qpfet_core_timing_chk_inst
   (
      .clock                    (clock),
      .reset                    (reset),
      .master_reset_n           (master_reset_n),
      .pc_load                  (pc_load),
      .pc_target                (pc_target),
      .program_word             (program_word),
      .program_address          (program_address),
      .instruction              (instruction),
      .instruction_valid        (instruction_valid),
      .phase_one                (phase_one),
      .phase_two                (phase_two),
      .phase_three              (phase_three),
      .phase_four               (phase_four),
      .operand_read             (operand_read),
      .destination_write        (destination_write),
      .oscillator_secondary_pin (oscillator_secondary_pin),
      .oscillator_secondary_oe  (oscillator_secondary_oe)
   );

// ### test/qpfet_prog_mem.sv
// Program memory model answering the core's fetch address
`timescale 1ns/1ps
module qpfet_prog_mem (
   input  wire logic [10:0] address,
   output logic      [11:0] word
);
   // Contents follow the address so every fetch can be predicted
   assign word = {1'b0, address} ^ 12'h5a3;
endmodule : qpfet_prog_mem
